// [feb_integrity.sv]
// boot checksum walk, flash check bits, watchdog reset and pin safing
//
// Function
// - checksum the firmware region on every power-up before letting firmware run.
// - on firmware mismatch stay idle but keep accepting serial commands.
// - check configuration checksum at power-up; on mismatch serve factory defaults.
// - configuration failure asserts fault_alert_n low and sets a status bit.
// - checksum the error-log region to confirm logged entries are intact.
// - firmware watchdog expiry issues a full normal device reset.
// - during reset general pins are released and fast pwm pins driven low.
// - check each incoming parameter against its permitted range before accepting.
// - generate six check bits per 32-bit word written, storing 38 bits.
// - on every flash read correct any single-bit error in the word.
module feb_integrity #(
	parameter int              GPIO_N      = 8,
	parameter int              PWM_N       = 4,
	parameter int              PAR_W       = 16,
	parameter int              WDT_CYCLES  = feb_pkg::WDT_CYCLES,
	parameter logic [31:0]     CFG_DEFAULT = 32'h0000_0000
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	output logic                              flash_req,
	output logic                              flash_we,
	output logic [feb_pkg::ADDR_W-1:0]        flash_addr,
	output logic [feb_pkg::CODE_W-1:0]        flash_wdata,
	input  wire logic [feb_pkg::CODE_W-1:0]   flash_rdata,
	input  wire logic                         flash_rvalid,
	input  wire logic                         host_req,
	input  wire logic                         host_we,
	input  wire logic [feb_pkg::ADDR_W-1:0]   host_addr,
	input  wire logic [feb_pkg::DATA_W-1:0]   host_wdata,
	output logic                              host_ready,
	output logic                              host_rvalid,
	output logic [feb_pkg::DATA_W-1:0]        host_rdata,
	output logic                              host_fixed,
	output logic                              host_err,
	input  wire logic                         par_valid,
	input  wire logic [PAR_W-1:0]             par_value,
	input  wire logic [PAR_W-1:0]             par_min,
	input  wire logic [PAR_W-1:0]             par_max,
	output logic                              par_ok,
	output logic                              par_bad,
	input  wire logic                         wdt_kick,
	input  wire logic [GPIO_N-1:0]            fw_gpio_oe,
	input  wire logic [PWM_N-1:0]             fw_pwm,
	output logic [GPIO_N-1:0]                 gpio_out,
	output logic [GPIO_N-1:0]                 gpio_oe,
	output logic [PWM_N-1:0]                  fast_pulse_width_output,
	output logic                              boot_done,
	output logic                              fw_run,
	output logic                              fw_bad,
	output logic                              cfg_default_sel,
	output logic                              status_cfg_bad,
	output logic                              fault_alert_n,
	output logic                              log_ok,
	output logic                              wdt_reset
);
	localparam int AW = feb_pkg::ADDR_W;
	localparam int DW = feb_pkg::DATA_W;
	localparam int CW = feb_pkg::CHK_W;
	localparam logic [31:0] WDT_LAST  = 32'(WDT_CYCLES - 1);
	localparam logic [7:0]  HOLD_LAST = 8'(feb_pkg::WDT_HOLD_CYCLES - 1);

	if (WDT_CYCLES < 2 || GPIO_N < 1 || PWM_N < 1 || PAR_W < 1) begin : g_chk
		$error("feb_integrity: unsupported parameter value");
	end

	// region base and length lookups, used only by the boot walk
	function automatic logic [AW-1:0] rgn_base(input logic [1:0] r);
		unique case (r)
			feb_pkg::RGN_FW:  return feb_pkg::FW_BASE;
			feb_pkg::RGN_CFG: return feb_pkg::CFG_BASE;
			default:          return feb_pkg::LOG_BASE;
		endcase
	endfunction

	function automatic logic [AW-1:0] rgn_len(input logic [1:0] r);
		unique case (r)
			feb_pkg::RGN_FW:  return feb_pkg::FW_LEN;
			feb_pkg::RGN_CFG: return feb_pkg::CFG_LEN;
			default:          return feb_pkg::LOG_LEN;
		endcase
	endfunction

	// internal reset: pin reset or watchdog reset
	logic in_rst;
	logic wdt_rst_q, wdt_rst_d;
	assign in_rst = rst | wdt_rst_q;

	// read decode shared by boot walk and host reads
	logic [DW-1:0] rd_raw, rd_fix;
	logic [CW-1:0] rd_syn;
	logic          rd_bad;
	assign rd_raw = flash_rdata[DW-1:0];
	assign rd_syn = feb_pkg::ecc_syn(rd_raw) ^ flash_rdata[feb_pkg::CODE_W-1:DW];
	assign rd_fix = feb_pkg::ecc_fix(rd_raw, rd_syn);
	assign rd_bad = feb_pkg::ecc_bad(rd_syn);

	// boot walk and flash access state
	feb_pkg::feb_state_e st_q, st_d;
	logic [1:0]              rgn_q, rgn_d;
	logic [AW-1:0]           idx_q, idx_d, haddr_q, haddr_d;
	logic [DW-1:0]           sum_q, sum_d, hdata_q, hdata_d;
	logic                    fw_ok_q, fw_ok_d, cfg_bad_q, cfg_bad_d, log_ok_q, log_ok_d;
	logic                    done_q, done_d, run_q, run_d, hpend_q, hpend_d;
	logic                    freq_q, freq_d, fwe_q, fwe_d, hval_q, hval_d;
	logic                    hfix_q, hfix_d, herr_q, herr_d;
	logic [AW-1:0]           faddr_q, faddr_d;
	logic [feb_pkg::CODE_W-1:0] fwd_q, fwd_d;
	logic                    in_cfg;

	assign in_cfg = haddr_q >= feb_pkg::CFG_BASE && haddr_q < feb_pkg::CFG_BASE + feb_pkg::CFG_LEN;
	// host requests wait for the boot walk; serial commands do not depend on firmware
	assign host_ready = (st_q == feb_pkg::FEB_RUN) && !freq_q && !hpend_q;

	// next state of the walk, flash requests and host answers
	always_comb begin
		st_d = st_q; rgn_d = rgn_q; idx_d = idx_q; sum_d = sum_q;
		fw_ok_d = fw_ok_q; cfg_bad_d = cfg_bad_q; log_ok_d = log_ok_q;
		done_d = done_q; hpend_d = hpend_q; haddr_d = haddr_q;
		freq_d = 1'b0; fwe_d = 1'b0; faddr_d = faddr_q; fwd_d = fwd_q;
		hval_d = 1'b0; hdata_d = hdata_q; hfix_d = hfix_q; herr_d = herr_q;
		run_d = done_q && fw_ok_q;
		unique case (st_q)
			feb_pkg::FEB_ISSUE: begin
				freq_d = 1'b1;
				faddr_d = rgn_base(rgn_q) + idx_q;
				st_d = feb_pkg::FEB_WAIT;
			end
			feb_pkg::FEB_WAIT: begin
				if (flash_rvalid) begin
					if (idx_q == rgn_len(rgn_q)) begin
						// stored checksum word reached: compare running sum
						unique case (rgn_q)
							feb_pkg::RGN_FW:  fw_ok_d = sum_q == rd_fix && !rd_bad;
							feb_pkg::RGN_CFG: cfg_bad_d = sum_q != rd_fix || rd_bad;
							default:          log_ok_d = sum_q == rd_fix && !rd_bad;
						endcase
						idx_d = '0;
						sum_d = '0;
						if (rgn_q == feb_pkg::RGN_LOG) begin
							st_d = feb_pkg::FEB_RUN;
							done_d = 1'b1;
						end else begin
							rgn_d = rgn_q + 2'h1;
							st_d = feb_pkg::FEB_ISSUE;
						end
					end else begin
						sum_d = sum_q + rd_fix;
						idx_d = idx_q + AW'(1);
						st_d = feb_pkg::FEB_ISSUE;
					end
				end
			end
			feb_pkg::FEB_RUN: begin
				if (hpend_q && flash_rvalid) begin
					hpend_d = 1'b0;
					hval_d = 1'b1;
					// a bad configuration is never served: defaults stand in
					hdata_d = (cfg_bad_q && in_cfg) ? CFG_DEFAULT : rd_fix;
					hfix_d = rd_syn != '0 && !rd_bad;
					herr_d = rd_bad;
				end else if (host_req && host_ready) begin
					freq_d = 1'b1;
					fwe_d = host_we;
					faddr_d = host_addr;
					haddr_d = host_addr;
					fwd_d = {feb_pkg::ecc_syn(host_wdata), host_wdata};
					hpend_d = !host_we;
				end
			end
		endcase
	end

	// walk and flash registers; the watchdog reset restarts the walk
	always_ff @(posedge clk) begin
		if (in_rst) begin
			st_q <= feb_pkg::FEB_ISSUE; rgn_q <= feb_pkg::RGN_FW;
			idx_q <= '0; sum_q <= '0; haddr_q <= '0; hdata_q <= '0;
			fw_ok_q <= 1'b0; cfg_bad_q <= 1'b0; log_ok_q <= 1'b0;
			done_q <= 1'b0; run_q <= 1'b0; hpend_q <= 1'b0;
			freq_q <= 1'b0; fwe_q <= 1'b0; faddr_q <= '0; fwd_q <= '0;
			hval_q <= 1'b0; hfix_q <= 1'b0; herr_q <= 1'b0;
		end else begin
			st_q <= st_d; rgn_q <= rgn_d; idx_q <= idx_d; sum_q <= sum_d;
			haddr_q <= haddr_d; hdata_q <= hdata_d;
			fw_ok_q <= fw_ok_d; cfg_bad_q <= cfg_bad_d; log_ok_q <= log_ok_d;
			done_q <= done_d; run_q <= run_d; hpend_q <= hpend_d;
			freq_q <= freq_d; fwe_q <= fwe_d; faddr_q <= faddr_d; fwd_q <= fwd_d;
			hval_q <= hval_d; hfix_q <= hfix_d; herr_q <= herr_d;
		end
	end

	assign flash_req = freq_q;
	assign flash_we = fwe_q;
	assign flash_addr = faddr_q;
	assign flash_wdata = fwd_q;
	assign host_rvalid = hval_q;
	assign host_rdata = hdata_q;
	assign host_fixed = hfix_q;
	assign host_err = herr_q;
	assign boot_done = done_q;
	assign fw_run = run_q;
	assign fw_bad = done_q && !fw_ok_q;
	assign cfg_default_sel = cfg_bad_q;
	assign status_cfg_bad = cfg_bad_q;
	assign log_ok = log_ok_q;

	// watchdog: counts only while firmware runs; only the pin reset clears it
	logic [31:0] wdt_cnt_q, wdt_cnt_d;
	logic [7:0]  hold_q, hold_d;
	always_comb begin
		wdt_cnt_d = wdt_cnt_q;
		hold_d = hold_q;
		wdt_rst_d = wdt_rst_q;
		if (wdt_rst_q) begin
			wdt_cnt_d = '0;
			hold_d = hold_q + 8'h01;
			if (hold_q == HOLD_LAST) wdt_rst_d = 1'b0;
		end else if (!run_q || wdt_kick) begin
			wdt_cnt_d = '0;
		end else if (wdt_cnt_q == WDT_LAST) begin
			wdt_rst_d = 1'b1;
			hold_d = '0;
		end else begin
			wdt_cnt_d = wdt_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdt_cnt_q <= '0; hold_q <= '0; wdt_rst_q <= 1'b0;
		end else begin
			wdt_cnt_q <= wdt_cnt_d; hold_q <= hold_d; wdt_rst_q <= wdt_rst_d;
		end
	end
	assign wdt_reset = wdt_rst_q;

	// pin safing and parameter range check
	logic [GPIO_N-1:0] goe_q, goe_d;
	logic [PWM_N-1:0]  pwm_q, pwm_d;
	logic              pok_q, pok_d, pbad_q, pbad_d, alert_n_q, alert_n_d;
	always_comb begin
		goe_d = fw_gpio_oe & {GPIO_N{run_q}};
		pwm_d = fw_pwm & {PWM_N{run_q}};
		// the range check runs even when firmware is held idle
		pok_d = par_valid && par_value >= par_min && par_value <= par_max;
		pbad_d = par_valid && !pok_d;
		alert_n_d = !cfg_bad_q;
	end

	always_ff @(posedge clk) begin
		if (in_rst) begin
			goe_q <= '0; pwm_q <= '0;
			pok_q <= 1'b0; pbad_q <= 1'b0; alert_n_q <= 1'b1;
		end else begin
			goe_q <= goe_d; pwm_q <= pwm_d;
			pok_q <= pok_d; pbad_q <= pbad_d; alert_n_q <= alert_n_d;
		end
	end
	// open-drain: the pin only ever pulls low
	assign gpio_out = '0;
	assign gpio_oe = goe_q;
	assign fast_pulse_width_output = pwm_q;
	assign par_ok = pok_q;
	assign par_bad = pbad_q;
	assign fault_alert_n = alert_n_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_run_needs_fw: assert property (fw_run |-> boot_done && fw_ok_q)
		else $error("firmware runs without a good checksum");
	chk_bad_fw_idle: assert property (fw_bad |-> !fw_run && gpio_oe == '0)
		else $error("bad firmware is running");
	chk_cfg_alert: assert property ($rose(cfg_bad_q) |=> !fault_alert_n && status_cfg_bad)
		else $error("config failure did not raise alert");
	chk_cfg_default: assert property (hval_d && cfg_bad_q && in_cfg |=> host_rdata == CFG_DEFAULT)
		else $error("bad config served instead of defaults");
	chk_log_walk: assert property ($rose(boot_done) |-> rgn_q == feb_pkg::RGN_LOG)
		else $error("boot finished before the log region");
	chk_wdt_fire: assert property (run_q && !wdt_kick && !wdt_rst_q && wdt_cnt_q == WDT_LAST
		|=> wdt_reset ##1 !fw_run)
		else $error("watchdog did not reset the device");
	chk_pins_reset: assert property (wdt_reset |=> gpio_oe == '0 && fast_pulse_width_output == '0)
		else $error("pins not safe during reset");
	chk_param_range: assert property (par_valid && par_value > par_max |=> par_bad && !par_ok)
		else $error("out of range parameter accepted");
	chk_write_code: assert property (flash_req && flash_we
		|-> flash_wdata[feb_pkg::CODE_W-1:DW] == feb_pkg::ecc_syn(flash_wdata[DW-1:0]))
		else $error("stored check bits do not match data");
	// a single-error code may change at most one data bit of what the array returned
	chk_read_fix: assert property (hval_d && !rd_bad && !(cfg_bad_q && in_cfg)
		|=> !host_err && $countones(host_rdata ^ $past(rd_raw)) <= 1)
		else $error("read data not corrected");

	cov_fw_bad: cover property ($rose(fw_bad));
	cov_cfg_bad: cover property ($rose(cfg_bad_q));
	cov_fixed_read: cover property (host_rvalid && host_fixed);
	cov_wdt: cover property ($rose(wdt_reset));
endmodule

// [feb_pkg.sv]
// constants, region map and check-bit functions for the flash integrity block
package feb_pkg;
	// clock and watchdog timing
	localparam int CLK_HZ          = 50_000_000;
	localparam int WDT_TIMEOUT_MS  = 100;
	localparam int WDT_CYCLES      = WDT_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int WDT_HOLD_CYCLES = 16;

	// word and codeword layout
	localparam int DATA_W = 32;
	localparam int CHK_W  = 6;
	localparam int CODE_W = DATA_W + CHK_W;
	localparam int ADDR_W = 10;

	// flash regions; each region's checksum word sits at base + len
	localparam logic [ADDR_W-1:0] FW_BASE  = 10'h000;
	localparam logic [ADDR_W-1:0] FW_LEN   = 10'h100;
	localparam logic [ADDR_W-1:0] CFG_BASE = 10'h120;
	localparam logic [ADDR_W-1:0] CFG_LEN  = 10'h040;
	localparam logic [ADDR_W-1:0] LOG_BASE = 10'h180;
	localparam logic [ADDR_W-1:0] LOG_LEN  = 10'h080;

	// region walk order
	localparam logic [1:0] RGN_FW  = 2'h0;
	localparam logic [1:0] RGN_CFG = 2'h1;
	localparam logic [1:0] RGN_LOG = 2'h2;

	typedef enum logic [1:0] {FEB_ISSUE, FEB_WAIT, FEB_RUN} feb_state_e;

	// hamming syndrome: xor of codeword positions of set data bits
	function automatic logic [CHK_W-1:0] ecc_syn(input logic [DATA_W-1:0] d);
		logic [CHK_W-1:0] s;
		int               k;
		s = '0;
		k = 0;
		for (int p = 1; p <= CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k]) s = s ^ CHK_W'(p);
				k++;
			end
		end
		return s;
	endfunction

	// flip the data bit that the syndrome points at, if any
	function automatic logic [DATA_W-1:0] ecc_fix(input logic [DATA_W-1:0] d,
		input logic [CHK_W-1:0] s);
		logic [DATA_W-1:0] r;
		int                k;
		r = d;
		k = 0;
		for (int p = 1; p <= CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (CHK_W'(p) == s) r[k] = ~r[k];
				k++;
			end
		end
		return r;
	endfunction

	// syndrome beyond the last codeword position: more than one bit flipped
	function automatic logic ecc_bad(input logic [CHK_W-1:0] s);
		return s > CHK_W'(CODE_W);
	endfunction
endpackage

// [feb_flash_model.sv]
// behavioural data flash array facing the integrity block
module feb_flash_model (
	input  wire logic                       clk,
	input  wire logic                       flash_req,
	input  wire logic                       flash_we,
	input  wire logic [feb_pkg::ADDR_W-1:0] flash_addr,
	input  wire logic [feb_pkg::CODE_W-1:0] flash_wdata,
	output logic [feb_pkg::CODE_W-1:0]      flash_rdata,
	output logic                            flash_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [feb_pkg::CODE_W-1:0] mem [0:(1<<feb_pkg::ADDR_W)-1];
	logic [feb_pkg::ADDR_W-1:0] addr_q;
	logic [1:0]                 wait_q;
	logic                       busy_q;
	initial begin
		flash_rvalid = 1'b0;
		flash_rdata = '0;
		busy_q = 1'b0;
	end
	// one read at a time, random delay; data toggles outside answers so stale words never match
	always @(posedge clk) begin
		flash_rvalid <= 1'b0;
		flash_rdata <= ~flash_rdata;
		if (flash_req && flash_we) mem[flash_addr] <= flash_wdata;
		if (flash_req && !flash_we) begin
			busy_q <= 1'b1;
			addr_q <= flash_addr;
			wait_q <= 2'($urandom_range(2, 0));
		end else if (busy_q && wait_q == 2'h0) begin
			busy_q <= 1'b0;
			flash_rvalid <= 1'b1;
			flash_rdata <= mem[addr_q];
		end else if (busy_q) wait_q <= wait_q - 2'h1;
	end
endmodule

// [feb_integrity_test.sv]
// self-checking bench for the flash integrity block
module feb_integrity_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] DEF = 32'hA5C3_0F96;
	localparam int          SEL_RDY  = 0;
	localparam int          SEL_RVAL = 1;
	localparam int          SEL_DONE = 2;
	localparam int          SEL_WDT  = 3;
	logic        clk, rst, flash_req, flash_we, flash_rvalid, host_req, host_we, host_ready;
	logic        host_rvalid, host_fixed, host_err, par_valid, par_ok, par_bad, wdt_kick;
	logic        boot_done, fw_run, fw_bad, cfg_default_sel, status_cfg_bad, fault_alert_n;
	logic        log_ok, wdt_reset;
	logic [9:0]  flash_addr, host_addr;
	logic [37:0] flash_wdata, flash_rdata;
	logic [31:0] host_wdata, host_rdata, fw_sum, cfg_sum, log_sum, dv [4];
	logic [15:0] par_value, par_min, par_max;
	logic [7:0]  fw_gpio_oe, gpio_out, gpio_oe;
	logic [3:0]  fw_pwm, fast_pulse_width_output;
	logic [37:0] masks [4] = '{38'h0, 38'h10, 38'h04_0000_0000, 38'h20_0000_0008};
	int          miscompares, checked, seed, mn, mx, v;
	feb_integrity #(.WDT_CYCLES(50), .CFG_DEFAULT(DEF)) feb_integrity_i (.*);
	feb_flash_model feb_flash_model_i (.clk(clk), .flash_req(flash_req), .flash_we(flash_we),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
		.flash_rvalid(flash_rvalid));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// expected codeword: data bits fill the non-power-of-two positions 1..38
	function automatic logic [37:0] enc(input logic [31:0] d);
		logic [5:0] c;
		int         k;
		c = '0;
		k = 0;
		for (int p = 3; p <= 38; p++) if ((p & (p - 1)) != 0) begin
			if (d[k]) c ^= 6'(p);
			k++;
		end
		return {c, d};
	endfunction
	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic chk_word(input logic [37:0] got, input logic [37:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// picks the output to wait on; a selector avoids passing a port net by reference
	function automatic logic pick(input int sel);
		case (sel)
			SEL_RDY:  return host_ready;
			SEL_RVAL: return host_rvalid;
			SEL_DONE: return boot_done;
			default:  return wdt_reset;
		endcase
	endfunction
	// bounded wait, sampled at the falling edge where outputs have settled
	task automatic wait_hi(input int sel, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge clk);
			if (pick(sel) === 1'b1) break;
		end
		if (i == n) begin
			miscompares++;
			$display("[FAIL] %0t wait ran out", $time);
			print_verdict();
		end
	endtask
	// request held until the edge where ready is high; reads wait for the answer pulse
	task automatic host(input logic we, input logic [9:0] a, input logic [31:0] d);
		wait_hi(SEL_RDY, 50);
		@(posedge clk);
		host_req <= 1'b1;
		host_we <= we;
		host_addr <= a;
		host_wdata <= d;
		wait_hi(SEL_RDY, 50);
		@(posedge clk);
		host_req <= 1'b0;
		if (!we) wait_hi(SEL_RVAL, 50);
	endtask
	task automatic par(input logic [15:0] pv, input logic [15:0] lo, input logic [15:0] hi);
		@(posedge clk);
		par_valid <= 1'b1;
		par_value <= pv;
		par_min <= lo;
		par_max <= hi;
		@(posedge clk);
		par_valid <= 1'b0;
		@(negedge clk);
		chk_bit(par_ok, lo <= pv && pv <= hi, "range ok");
		chk_bit(par_bad, !(lo <= pv && pv <= hi), "range bad");
	endtask
	// region words plus a trailing additive checksum, optionally wrong
	task automatic fill(input logic [9:0] b, input logic [9:0] n, input logic good,
		output logic [31:0] s);
		logic [31:0] d;
		s = '0;
		for (int i = 0; i < n; i++) begin
			d = $urandom;
			feb_flash_model_i.mem[b + 10'(i)] = enc(d);
			s += d;
		end
		feb_flash_model_i.mem[b + n] = enc(good ? s : s + 32'h1);
	endtask
	initial begin
		{rst, host_req, host_we, par_valid, wdt_kick} = 5'h10;
		{host_addr, host_wdata, par_value, par_min, par_max, fw_gpio_oe, fw_pwm} = '0;
		miscompares = 0;
		checked = 0;
		seed = $urandom(53374);
		fill(feb_pkg::FW_BASE, feb_pkg::FW_LEN, 1'b1, fw_sum);
		fill(feb_pkg::CFG_BASE, feb_pkg::CFG_LEN, 1'b0, cfg_sum);
		fill(feb_pkg::LOG_BASE, feb_pkg::LOG_LEN, 1'b1, log_sum);
		feb_flash_model_i.mem[feb_pkg::FW_BASE + 10'h5] ^= 38'h100;
		@(posedge clk);
		fw_gpio_oe <= 8'hFF;
		fw_pwm <= 4'hF;
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk_word(38'({gpio_oe, fast_pulse_width_output}), 38'h0, "pins in reset");
		chk_bit(fault_alert_n, 1'b1, "alert idle in reset");
		@(posedge clk);
		rst <= 1'b0;
		wdt_kick <= 1'b1;
		wait_hi(SEL_DONE, 6000);
		chk_bit(fw_run, 1'b0, "run before sums");
		@(negedge clk);
		chk_bit(fw_run, 1'b1, "firmware runs");
		chk_bit(fw_bad, 1'b0, "firmware sum");
		chk_bit(cfg_default_sel & status_cfg_bad, 1'b1, "config flagged");
		chk_bit(fault_alert_n, 1'b0, "alert asserted");
		chk_bit(log_ok, 1'b1, "log sum");
		@(posedge clk);
		fw_gpio_oe <= 8'($urandom);
		fw_pwm <= 4'($urandom);
		repeat (2) @(negedge clk);
		chk_word(38'({gpio_out, gpio_oe, fast_pulse_width_output}), 38'({8'h0, fw_gpio_oe, fw_pwm}),
			"pins follow firmware");
		for (int i = 0; i < 12; i++) begin
			mn = $urandom_range(300, 0);
			mx = mn + $urandom_range(300, 0);
			v = (i == 0) ? mn : (i == 1) ? mx : (i == 2) ? mx + 1 : (i == 3) ? mn - 1 :
				$urandom_range(700, 0);
			par(16'(v), 16'(mn), 16'(mx));
		end
		// write, corrupt in the array, read back: clean, data bit, check bit, double
		for (int i = 0; i < 4; i++) begin
			dv[i] = $urandom;
			host(1'b1, 10'h200 + 10'(i), dv[i]);
			repeat (3) @(negedge clk);
			chk_word(feb_flash_model_i.mem[10'h200 + 10'(i)], enc(dv[i]), "stored code");
			feb_flash_model_i.mem[10'h200 + 10'(i)] ^= masks[i];
			host(1'b0, 10'h200 + 10'(i), 32'h0);
			if (i < 3) chk_word(38'(host_rdata), 38'(dv[i]), "corrected data");
			chk_bit(host_fixed, i == 1 || i == 2, "fixed flag");
			chk_bit(host_err, i == 3, "double error");
		end
		host(1'b0, feb_pkg::CFG_BASE + 10'h5, 32'h0);
		chk_word(38'(host_rdata), 38'(DEF), "factory default");
		// second boot: bad firmware sum, good config, bad log sum
		feb_flash_model_i.mem[feb_pkg::FW_BASE + feb_pkg::FW_LEN] = enc(fw_sum + 32'h1);
		feb_flash_model_i.mem[feb_pkg::CFG_BASE + feb_pkg::CFG_LEN] = enc(cfg_sum);
		feb_flash_model_i.mem[feb_pkg::LOG_BASE + feb_pkg::LOG_LEN] = enc(log_sum + 32'h1);
		@(posedge clk);
		wdt_kick <= 1'b0;
		wait_hi(SEL_WDT, 60);
		@(negedge clk);
		chk_word(38'({gpio_oe, fast_pulse_width_output, fw_run}), 38'h0, "pins in wdt reset");
		wait_hi(SEL_DONE, 8000);
		@(negedge clk);
		chk_bit(fw_bad, 1'b1, "firmware mismatch");
		chk_bit(fw_run, 1'b0, "firmware held");
		chk_bit(log_ok, 1'b0, "log mismatch");
		chk_bit(fault_alert_n & !status_cfg_bad, 1'b1, "config good");
		host(1'b0, 10'h201, 32'h0);
		chk_word(38'(host_rdata), 38'(dv[1]), "commands served idle");
		print_verdict();
	end
endmodule
